// ==== hw/vdma_pkg.sv ====
// Behaviour
// - Level-7 request launches engine when routed; code also needs fast irq select clear
// - Routed level-7 requests never reach CPU; code forwards them when fast irq select set
// - Launch ignores CPU enable flag and level
// - Higher-priority events serviced before transfer starts
// - Increment by one or two, else fixed
// - Addresses in low region or high region
// - 16-bit at top byte also touches zero
// - Single mode: one transfer per trigger
// - Burst mode: transfer until counter exhausted
// - Multiple mode: one transfer per address pair
// - Chained mode uses linked descriptor next
// - Completion interrupt when counter reaches zero
// - Descriptor is RAM table, 12 to 60 bytes
// - Descriptor fields in fixed order, needed only
// - Mode word and counter two bytes each
// - Immediate source ignores upper two bytes
// - Calculation adds source and operand, writes sum
// - Chain base gives next descriptor address
// - Handler address taken from completion vector field
// - Multiple mode: up to seven pairs, plain
// - Descriptor address read from peripheral vector
// - Counter decrements; zero counter means no transfer
// - Chained end rewrites vector with chain base
// - Pair count 001b to 111b, never zero
// - Past low region top, access high region
package vdma_pkg;

    // ****************************************************************
    // Mode word fields
    // ****************************************************************
    localparam int MW_SIZE16  = 0;
    localparam int MW_IMM_N   = 1;
    localparam int MW_UPDS    = 2;
    localparam int MW_UPDD    = 3;
    localparam int MW_OPER    = 4;
    localparam int MW_BRST    = 5;
    localparam int MW_INTE    = 6;
    localparam int MW_CHAIN   = 7;
    localparam int MW_MULT    = 8;
    localparam int MW_CNT_LSB = 9;

    // ****************************************************************
    // Addresses and constants
    // ****************************************************************
    localparam logic [2:0]  LEVEL_DMA     = 3'h7;
    localparam logic [31:0] LOW_TOP       = 32'h01ffffff;
    localparam logic [31:0] HIGH_BASE     = 32'hfe000000;
    localparam logic [31:0] ADDR_TOP      = 32'hffffffff;
    localparam logic [31:0] ADDR_ZERO     = 32'h00000000;
    localparam logic [31:0] LOW_END_PLUS  = 32'h02000000;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [5:0]  OFS_COUNT     = 6'h02;
    localparam logic [5:0]  OFS_SRC       = 6'h04;
    localparam logic [31:0] VEC_STEP      = 32'h00000004;
    localparam logic [2:0]  PAIRS_MIN     = 3'h1;

    typedef enum logic [3:0] {
        VDMA_IDLE, VDMA_VEC, VDMA_FETCH, VDMA_RD, VDMA_OPRD, VDMA_WR,
        VDMA_WRAP, VDMA_NEXT, VDMA_WB, VDMA_DONE
    } vdma_state_e;

endpackage

// ==== hw/vdma_bus_if.sv ====
`timescale 1ns/100ps
// Shared memory-port signals between engine core and bus adapter.
interface vdma_bus_if;
    logic        req;
    logic        we;
    logic        wide;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    modport core (output req, we, wide, addr, wdata, input ack, rdata);
    modport port (input req, we, wide, addr, wdata, output ack, rdata);
endinterface

// ==== hw/vdma_mem_port.sv ====
`timescale 1ns/100ps
// Registers one access onto the system bus and returns the answer.
module vdma_mem_port
    import vdma_pkg::*;
(
    input  wire logic   sys_clk_in,     // Clock
    input  wire logic   resetn_in,      // Async reset, low
    vdma_bus_if.port    bus,            // Engine side
    output logic        mreq_out,       // Bus request
    output logic        mwe_out,        // Write strobe
    output logic        mwide_out,      // 16-bit access
    output logic [31:0] maddr_out,      // Address
    output logic [15:0] mwdata_out,     // Write data
    input  wire logic   mack_in,        // Bus done
    input  wire logic [15:0] mrdata_in  // Read data
);
    logic busy_q;

    assign bus.ack   = busy_q & mack_in;
    assign bus.rdata = mrdata_in;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_q     <= 1'b0;
            mreq_out   <= 1'b0;
            mwe_out    <= 1'b0;
            mwide_out  <= 1'b0;
            maddr_out  <= 32'h0;
            mwdata_out <= 16'h0;
        end else if (busy_q) begin
            if (mack_in) begin
                busy_q   <= 1'b0;
                mreq_out <= 1'b0;
            end
        end else if (bus.req) begin
            busy_q     <= 1'b1;
            mreq_out   <= 1'b1;
            mwe_out    <= bus.we;
            mwide_out  <= bus.wide;
            maddr_out  <= bus.addr;
            mwdata_out <= bus.wdata;
        end
    end
endmodule // vdma_mem_port

// ==== hw/vdma_engine.sv ====
`timescale 1ns/100ps
module vdma_engine
    import vdma_pkg::*;
(
    input  wire logic        sys_clk_in,           // Clock, 200 MHz
    input  wire logic        resetn_in,            // Async reset, low
    input  wire logic        irq_valid_in,         // Peripheral request pulse
    input  wire logic [2:0]  irq_priority_field_in,// Request level
    input  wire logic [7:0]  irq_vector_in,        // Vector number
    input  wire logic [31:0] vector_base_in,       // Relocatable table base
    input  wire logic        level7_dma_route_in,  // Route level 7 to engine
    input  wire logic        fast_irq_select_in,   // Level 7 is fast irq
    input  wire logic        hi_prio_busy_in,      // Higher event sequence running
    output logic             irq_to_cpu_out,       // Forwarded request pulse
    output logic [7:0]       irq_to_cpu_vec_out,   // Forwarded vector
    output logic             busy_out,             // Engine active
    output logic             done_irq_out,         // Completion request pulse
    output logic [31:0]      done_vector_out,      // Handler address
    output logic             mreq_out,             // Bus request
    output logic             mwe_out,              // Bus write
    output logic             mwide_out,            // 16-bit access
    output logic [31:0]      maddr_out,            // Bus address
    output logic [15:0]      mwdata_out,           // Bus write data
    input  wire logic        mack_in,              // Bus done
    input  wire logic [15:0] mrdata_in             // Bus read data
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Low-region addresses past the top are steered to the high region.
    function automatic logic [31:0] phys(input logic [31:0] a);
        phys = (a > LOW_TOP && a < HIGH_BASE) ? (a - LOW_END_PLUS + HIGH_BASE) : a;
    endfunction

    function automatic logic [31:0] step(input logic [31:0] a, input logic w);
        step = a + (w ? 32'h2 : 32'h1);
    endfunction

    vdma_bus_if bus();

    vdma_mem_port u_port (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .bus        (bus),
        .mreq_out   (mreq_out),
        .mwe_out    (mwe_out),
        .mwide_out  (mwide_out),
        .maddr_out  (maddr_out),
        .mwdata_out (mwdata_out),
        .mack_in    (mack_in),
        .mrdata_in  (mrdata_in)
    );

    vdma_state_e state_q;
    logic [7:0]  vec_q;
    logic [31:0] vaddr_q;
    logic [31:0] base_q;
    logic [15:0] desc_q [0:29];
    logic [4:0]  fidx_q;
    logic [4:0]  flen_q;
    logic [15:0] mode_q;
    logic [15:0] cnt_q;
    logic [31:0] src_q;
    logic [31:0] opa_q;
    logic [31:0] dst_q;
    logic [15:0] data_q;
    logic [15:0] opd_q;
    logic [2:0]  pair_q;
    logic        wrap_q;
    logic        pend_q;
    logic [7:0]  pvec_q;
    logic        issued_q;

    // The word arriving on the bus this cycle is not yet in the table, so take it directly.
    function automatic logic [15:0] fresh(input logic [4:0] i);
        fresh = (i == fidx_q) ? bus.rdata : desc_q[i];
    endfunction

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire trig_hit   = irq_valid_in && irq_priority_field_in == LEVEL_DMA
                      && level7_dma_route_in && !fast_irq_select_in;
    wire wide       = mode_q[MW_SIZE16];
    wire imm        = !mode_q[MW_IMM_N];
    wire multi      = mode_q[MW_MULT];
    wire oper       = mode_q[MW_OPER] && !multi;
    wire chain      = mode_q[MW_CHAIN] && !multi;
    wire inte       = mode_q[MW_INTE] && !multi;
    wire brst       = mode_q[MW_BRST] && !multi;
    wire [2:0] npair = mode_q[MW_CNT_LSB +: 3];
    // Field layout: mode, count, src, [opa], dst, [chain], [vector].
    wire [4:0] w_dst   = oper ? 5'd6 : 5'd4;
    wire [4:0] w_chain = w_dst + 5'd2;
    wire [4:0] w_iv    = chain ? w_chain + 5'd2 : w_chain;
    wire [4:0] flen_hdr = 5'd2;
    wire [4:0] flen_all = multi ? 5'd2 + {npair, 2'b00}
                        : w_iv + (inte ? 5'd2 : 5'd0);
    wire [4:0] pw      = {pair_q - PAIRS_MIN, 2'b00} + 5'd2;
    wire [31:0] cur_src = multi ? {desc_q[pw+1], desc_q[pw]} : src_q;
    wire [31:0] cur_dst = multi ? {desc_q[pw+3], desc_q[pw+2]} : dst_q;
    wire [15:0] imm_val = wide ? src_q[15:0] : {8'h00, src_q[7:0]};
    wire [15:0] sum_val = data_q + opd_q;
    wire [15:0] out_val = oper ? sum_val : data_q;
    wire top_hit    = wide && (phys(cur_dst) == ADDR_TOP);
    wire last_pair  = pair_q == npair;
    wire cnt_next_z = cnt_q == 16'h0001;
    wire launch_ok  = state_q == VDMA_IDLE && !hi_prio_busy_in;
    // Write-back skips the operand field, so destination words land at their own slot.
    wire [4:0] wb_idx = fidx_q >= 5'd4 ? fidx_q - 5'd4 + w_dst : fidx_q;

    // ****************************************************************
    // Bus request steering
    // ****************************************************************
    logic        rq;
    logic        rwe;
    logic        rwide;
    logic [31:0] raddr;
    logic [15:0] rwd;
    always_comb begin
        rq    = !issued_q;
        rwe   = 1'b0;
        rwide = 1'b1;
        raddr = ADDR_ZERO;
        rwd   = 16'h0;
        case (state_q)
            VDMA_VEC:   raddr = vaddr_q;
            VDMA_FETCH: raddr = base_q + {26'h0, fidx_q, 1'b0};
            VDMA_RD: begin
                rwide = wide;
                raddr = phys(cur_src);
                if (imm && !multi)
                    rq = 1'b0;
            end
            VDMA_OPRD: begin
                rwide = wide;
                raddr = phys(opa_q);
            end
            VDMA_WR: begin
                rwe   = 1'b1;
                rwide = wide && !top_hit;
                raddr = phys(cur_dst);
                rwd   = out_val;
            end
            VDMA_WRAP: begin
                rwe   = 1'b1;
                rwide = 1'b0;
                raddr = ADDR_ZERO;
                rwd   = {8'h00, out_val[15:8]};
            end
            VDMA_WB: begin
                rwe   = 1'b1;
                raddr = wrap_q ? vaddr_q + {30'h0, fidx_q[0], 1'b0}
                               : base_q + {26'h0, wb_idx, 1'b0};
                rwd   = fidx_q == 5'd1 ? cnt_q
                      : fidx_q == 5'd2 ? src_q[15:0]
                      : fidx_q == 5'd3 ? src_q[31:16]
                      : fidx_q == 5'd4 ? dst_q[15:0] : dst_q[31:16];
                if (wrap_q)
                    rwd = fidx_q[0] ? desc_q[w_chain+1] : desc_q[w_chain];
            end
            default: rq = 1'b0;
        endcase
    end
    assign bus.req   = rq;
    assign bus.we    = rwe;
    assign bus.wide  = rwide;
    assign bus.addr  = raddr;
    assign bus.wdata = rwd;

    // ****************************************************************
    // Request front end
    // ****************************************************************
    // A second trigger while busy is held once; repeats merge into it.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pend_q             <= 1'b0;
            pvec_q             <= 8'h00;
            irq_to_cpu_out     <= 1'b0;
            irq_to_cpu_vec_out <= 8'h00;
        end else begin
            irq_to_cpu_out     <= irq_valid_in && !trig_hit;
            irq_to_cpu_vec_out <= irq_vector_in;
            if (trig_hit && !launch_ok) begin
                pend_q <= 1'b1;
                pvec_q <= irq_vector_in;
            end else if (launch_ok) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q         <= VDMA_IDLE;
            vec_q           <= 8'h00;
            vaddr_q         <= 32'h0;
            base_q          <= 32'h0;
            fidx_q          <= 5'd0;
            flen_q          <= 5'd0;
            mode_q          <= 16'h0;
            cnt_q           <= 16'h0;
            src_q           <= 32'h0;
            opa_q           <= 32'h0;
            dst_q           <= 32'h0;
            data_q          <= 16'h0;
            opd_q           <= 16'h0;
            pair_q          <= 3'h1;
            wrap_q          <= 1'b0;
            issued_q        <= 1'b0;
            busy_out        <= 1'b0;
            done_irq_out    <= 1'b0;
            done_vector_out <= 32'h0;
        end else begin
            done_irq_out <= 1'b0;
            if (bus.ack)
                issued_q <= 1'b0;
            else if (rq)
                issued_q <= 1'b1;
            case (state_q)
                VDMA_IDLE: begin
                    busy_out <= 1'b0;
                    if ((pend_q || trig_hit) && !hi_prio_busy_in) begin
                        vec_q    <= trig_hit ? irq_vector_in : pvec_q;
                        vaddr_q  <= vector_base_in
                                  + {22'h0, (trig_hit ? irq_vector_in : pvec_q), 2'b00};
                        fidx_q   <= 5'd0;
                        busy_out <= 1'b1;
                        state_q  <= VDMA_VEC;
                    end
                end
                VDMA_VEC: if (bus.ack) begin
                    if (fidx_q == 5'd0) begin
                        base_q[15:0] <= bus.rdata;
                        fidx_q       <= 5'd1;
                        vaddr_q      <= vaddr_q + 32'h2;
                    end else begin
                        base_q[31:16] <= bus.rdata;
                        vaddr_q       <= vaddr_q - 32'h2;
                        fidx_q        <= 5'd0;
                        flen_q        <= flen_hdr;
                        state_q       <= VDMA_FETCH;
                    end
                end
                VDMA_FETCH: if (bus.ack) begin
                    desc_q[fidx_q] <= bus.rdata;
                    if (fidx_q == 5'd0) begin
                        mode_q <= bus.rdata;
                        flen_q <= 5'd2;
                    end
                    if (fidx_q == 5'd1) begin
                        cnt_q  <= bus.rdata;
                        flen_q <= flen_all;
                    end
                    if (fidx_q + 5'd1 >= flen_q && fidx_q != 5'd0) begin
                        src_q <= {fresh(5'd3), fresh(5'd2)};
                        opa_q <= {fresh(5'd5), fresh(5'd4)};
                        dst_q <= {fresh(w_dst + 5'd1), fresh(w_dst)};
                        if (fidx_q == 5'd1) begin
                            src_q <= 32'h0;
                        end
                        pair_q <= PAIRS_MIN;
                        if (cnt_q == COUNT_ZERO && fidx_q != 5'd1)
                            state_q <= VDMA_DONE;
                        else if (fidx_q != 5'd1 || flen_all == 5'd2)
                            state_q <= VDMA_RD;
                        fidx_q <= fidx_q + 5'd1;
                    end else begin
                        fidx_q <= fidx_q + 5'd1;
                    end
                    if (fidx_q == 5'd1 && bus.rdata == COUNT_ZERO)
                        state_q <= VDMA_DONE;
                end
                VDMA_RD: begin
                    if (imm && !multi) begin
                        data_q  <= imm_val;
                        state_q <= oper ? VDMA_OPRD : VDMA_WR;
                    end else if (bus.ack) begin
                        data_q  <= wide ? bus.rdata : {8'h00, bus.rdata[7:0]};
                        state_q <= oper ? VDMA_OPRD : VDMA_WR;
                    end
                end
                VDMA_OPRD: if (bus.ack) begin
                    opd_q   <= wide ? bus.rdata : {8'h00, bus.rdata[7:0]};
                    state_q <= VDMA_WR;
                end
                VDMA_WR: if (bus.ack) begin
                    state_q <= top_hit ? VDMA_WRAP : VDMA_NEXT;
                end
                VDMA_WRAP: if (bus.ack) state_q <= VDMA_NEXT;
                VDMA_NEXT: begin
                    if (multi) begin
                        pair_q  <= pair_q + 3'h1;
                        state_q <= last_pair ? VDMA_WB : VDMA_RD;
                        if (last_pair) cnt_q <= cnt_q - 16'h1;
                        fidx_q  <= 5'd1;
                    end else begin
                        cnt_q <= cnt_q - 16'h1;
                        if (mode_q[MW_UPDS] && !imm) begin
                            src_q <= step(src_q, wide);
                            if (oper) opa_q <= step(opa_q, wide);
                        end
                        if (mode_q[MW_UPDD]) dst_q <= step(dst_q, wide);
                        fidx_q  <= 5'd1;
                        state_q <= (brst && !cnt_next_z) ? VDMA_RD : VDMA_WB;
                    end
                    wrap_q <= 1'b0;
                end
                VDMA_WB: if (bus.ack) begin
                    if (wrap_q) begin
                        fidx_q <= fidx_q + 5'd1;
                        if (fidx_q[0]) state_q <= VDMA_DONE;
                    end else if (fidx_q == 5'd5 || multi) begin
                        if (chain && cnt_q == COUNT_ZERO) begin
                            wrap_q <= 1'b1;
                            fidx_q <= 5'd0;
                        end else begin
                            state_q <= VDMA_DONE;
                        end
                    end else begin
                        fidx_q <= (fidx_q == 5'd3 && oper) ? 5'd4 : fidx_q + 5'd1;
                    end
                end
                VDMA_DONE: begin
                    if (inte && cnt_q == COUNT_ZERO && flen_q > 5'd2) begin
                        done_irq_out    <= 1'b1;
                        done_vector_out <= {desc_q[w_iv+1], desc_q[w_iv]};
                    end
                    wrap_q  <= 1'b0;
                    state_q <= VDMA_IDLE;
                end
                default: state_q <= VDMA_IDLE;
            endcase
        end
    end
endmodule // vdma_engine

// ==== bench/vdma_engine_assertions.sv ====
`timescale 1ns/100ps
module vdma_engine_checker
    import vdma_pkg::*;
(
    input wire logic        sys_clk_in,            // Clk
    input wire logic        resetn_in,             // Rst
    input wire logic        irq_valid_in,          // Req
    input wire logic [2:0]  irq_priority_field_in, // Lvl
    input wire logic [7:0]  irq_vector_in,         // Vec
    input wire logic [31:0] vector_base_in,        // Base
    input wire logic        level7_dma_route_in,   // Route
    input wire logic        fast_irq_select_in,    // Fast
    input wire logic        hi_prio_busy_in,       // Event
    input wire logic        irq_to_cpu_out,        // Fwd
    input wire logic        busy_out,              // Busy
    input wire logic        mreq_out,              // Req
    input wire logic        mwe_out,               // Wr
    input wire logic [31:0] maddr_out,             // Addr
    input wire logic        mack_in                // Ack
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    wire trig = irq_valid_in && irq_priority_field_in == LEVEL_DMA
        && level7_dma_route_in && !fast_irq_select_in;
    wire launch = trig && !busy_out && !hi_prio_busy_in;
    a_no_leak: assert property (trig |=> !irq_to_cpu_out)
        else $error("routed request forwarded");
    a_fwd_plain: assert property (irq_valid_in && !trig |=> irq_to_cpu_out)
        else $error("plain request lost");
    a_start_busy: assert property (launch |=> busy_out)
        else $error("engine not started");
    a_vec_fetch: assert property (launch && !hi_prio_busy_in ##1 !hi_prio_busy_in |=>
        mreq_out && !mwe_out && maddr_out == $past(vector_base_in, 2)
        + 32'({$past(irq_vector_in, 2), 2'b00})) else $error("vector entry not read");
    a_hold_off: assert property (trig && hi_prio_busy_in && !busy_out |=> !busy_out)
        else $error("transfer ahead of event");
    a_bus_hold: assert property (mreq_out && !mack_in |=> mreq_out && $stable(maddr_out))
        else $error("access dropped early");
    a_space_map: assert property (mreq_out |-> maddr_out <= LOW_TOP || maddr_out >= HIGH_BASE)
        else $error("address outside map");
    a_top_zero: assert property (mreq_out && mack_in && mwe_out && maddr_out == ADDR_TOP |->
        ##[1:4] mreq_out && mwe_out && maddr_out == ADDR_ZERO) else $error("zero byte missed");
endmodule // vdma_engine_checker
bind vdma_engine vdma_engine_checker vdma_engine_checker_i (.*);

// ==== bench/vdma_mem_model.sv ====
`timescale 1ns/100ps
module vdma_mem_model (
    input  wire logic        sys_clk_in, // Clk
    input  wire logic        mreq_in,    // Req
    input  wire logic        mwe_in,     // Wr
    input  wire logic        mwide_in,   // Wide
    input  wire logic [31:0] maddr_in,   // Addr
    input  wire logic [15:0] mwdata_in,  // Data
    output logic             mack_out,   // Ack
    output logic [15:0]      mrdata_out  // Data
);
    logic [7:0] mem [logic [31:0]];
    int         wait_q = 0;
    initial {mack_out, mrdata_out} = 17'h05a5a;
    function automatic logic [7:0] peek(logic [31:0] a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction
    // Waits zero to two cycles; read data toggles off the ack cycle so stale samples show.
    always @(posedge sys_clk_in) begin
        mack_out <= 1'b0;
        mrdata_out <= ~mrdata_out;
        if (mreq_in && !mack_out && wait_q > 0) wait_q <= wait_q - 1;
        else if (mreq_in && !mack_out) begin
            mack_out <= 1'b1;
            wait_q <= $urandom_range(2);
            if (mwe_in) mem[maddr_in] = mwdata_in[7:0];
            if (mwe_in && mwide_in) mem[maddr_in + 32'h1] = mwdata_in[15:8];
            if (!mwe_in) mrdata_out <= {peek(maddr_in + 32'h1), peek(maddr_in)};
        end
    end
endmodule // vdma_mem_model

// ==== bench/descriptor_driven_irq_dma_tb.sv ====
`timescale 1ns/100ps
module descriptor_driven_irq_dma_tb;
    import vdma_pkg::*;
    logic        clk = 0, rstn = 0, irq = 0, route = 1, fast = 0, hp = 0;
    logic [2:0]  prio = 3'h7;
    logic [7:0]  vec = 8'h00;
    logic [31:0] vb = 32'h00001000, dvec, maddr;
    logic        fwd, busy, dirq, req, we, wide, ack;
    logic [15:0] wdata, rdata;
    int          fail_count = 0, tests_run = 0, n_done = 0, n_fwd = 0;
    vdma_engine vdma_engine_i (.sys_clk_in(clk), .resetn_in(rstn), .irq_valid_in(irq),
        .irq_priority_field_in(prio), .irq_vector_in(vec), .vector_base_in(vb),
        .level7_dma_route_in(route), .fast_irq_select_in(fast), .hi_prio_busy_in(hp),
        .irq_to_cpu_out(fwd), .irq_to_cpu_vec_out(), .busy_out(busy), .done_irq_out(dirq),
        .done_vector_out(dvec), .mreq_out(req), .mwe_out(we), .mwide_out(wide),
        .maddr_out(maddr), .mwdata_out(wdata), .mack_in(ack), .mrdata_in(rdata));
    vdma_mem_model vdma_mem_model_i (.sys_clk_in(clk), .mreq_in(req), .mwe_in(we),
        .mwide_in(wide), .maddr_in(maddr), .mwdata_in(wdata), .mack_out(ack), .mrdata_out(rdata));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) n_done <= n_done + int'(dirq === 1'b1);
    always @(posedge clk) n_fwd <= n_fwd + int'(fwd === 1'b1);
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failed %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [15:0] g16(logic [31:0] a);
        return {vdma_mem_model_i.peek(a + 32'h1), vdma_mem_model_i.peek(a)};
    endfunction
    task automatic p16(logic [31:0] a, logic [15:0] v);
        vdma_mem_model_i.mem[a] = v[7:0];
        vdma_mem_model_i.mem[a + 32'h1] = v[15:8];
    endtask
    task automatic p32(logic [31:0] a, logic [31:0] v);
        p16(a, v[15:0]);
        p16(a + 32'h2, v[31:16]);
    endtask
    task automatic desc(logic [31:0] a, logic [15:0] mode, cnt, logic [31:0] f[$]);
        p16(a, mode);
        p16(a + 32'h2, cnt);
        foreach (f[i]) p32(a + 32'(4 * i + 4), f[i]);
    endtask
    // A zero table address leaves the vector entry alone, so a chained link survives.
    task automatic fire(logic [7:0] v, logic [31:0] d, int hold);
        if (d != 0) p32(vb + 32'({v, 2'b00}), d);
        @(posedge clk);
        irq <= 1'b1;
        vec <= v;
        hp <= hold > 0;
        @(posedge clk);
        irq <= 1'b0;
        repeat (hold + 3) @(posedge clk);
        hp <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
        check("idle", busy, 1'b0);
    endtask
    initial begin
        logic [31:0] x, y, a;
        logic [31:0] q[$];
        int n;
        void'($urandom(3));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        x = $urandom;
        y = $urandom;
        p32(32'h2000, {y[15:0], x[15:0]});
        desc(32'h3000, 16'h004f, 16'h0002, '{32'h2000, 32'hfe000100, 32'h0000abc0});
        fire(8'h01, 32'h3000, 0);
        check("single", g16(32'hfe000102), 16'h0000);
        check("count", g16(32'h3002), 16'h0001);
        fire(8'h01, 32'h0, 2);
        check("moved", {g16(32'hfe000102), g16(32'hfe000100)}, {y[15:0], x[15:0]});
        check("handler", dvec, 32'h0000abc0);
        check("done", n_done, 1);
        n = $urandom_range(5, 2);
        desc(32'h3100, 16'h0029, 16'(n), '{x, 32'h01fffffc});
        fire(8'h02, 32'h3100, 0);
        for (int i = 0; i <= n; i++) begin
            a = 32'h01fffffc + 32'(2 * i);
            if (a > LOW_TOP) a = a - LOW_END_PLUS + HIGH_BASE;
            check("burst", g16(a), i < n ? x[15:0] : 16'h0000);
        end
        desc(32'h3200, 16'h0013, 16'h0001, '{32'h2000, 32'h2002, 32'h2300});
        fire(8'h03, 32'h3200, 0);
        check("sum", g16(32'h2300), 16'(x[15:0] + y[15:0]));
        for (int i = 0; i < 7; i++) begin
            p16(32'h2400 + 32'(2 * i), {8'h00, 8'($urandom)});
            q.push_back(32'h2400 + 32'(2 * i));
            q.push_back(32'h2500 + 32'(2 * i));
        end
        desc(32'h3300, 16'h0f02, 16'h0001, q);
        fire(8'h04, 32'h3300, 0);
        for (int i = 0; i < 7; i++) check("pair", g16(q[2 * i + 1]), g16(q[2 * i]));
        desc(32'h3400, 16'h0080, 16'h0001, '{x, 32'h2600, 32'h3500});
        desc(32'h3500, 16'h0000, 16'h0001, '{y, 32'h2602});
        fire(8'h05, 32'h3400, 0);
        check("relink", g16(32'h1014), 16'h3500);
        fire(8'h05, 32'h0, 0);
        check("linked", g16(32'h2602), {8'h00, y[7:0]});
        desc(32'h3600, 16'h0001, 16'h0000, '{x, 32'h2700});
        fire(8'h06, 32'h3600, 0);
        check("zero count", g16(32'h2700), 16'h0000);
        desc(32'h3700, 16'h0001, 16'h0001, '{y, 32'hffffffff});
        fire(8'h07, 32'h3700, 0);
        check("top", g16(32'hffffffff), y[15:0]);
        check("done", n_done, 1);
        desc(32'h3800, 16'h0000, 16'h0001, '{32'h5a, 32'h2800});
        for (int k = 0; k < 2; k++) begin
            prio <= k == 0 ? 3'($urandom_range(6)) : 3'h7;
            route <= k == 0;
            fast <= k == 1;
            fire(8'h08, 32'h3800, 0);
            check("forwarded", n_fwd, k + 1);
        end
        check("not launched", g16(32'h2800), 16'h0000);
        give_verdict();
    end
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
endmodule // descriptor_driven_irq_dma_tb
